// ==== hdl/msi_and_frame_adjust_config.sv ====
// Contract
// RULE1: the low message address keeps bits 31:2 writable and reads bits 1:0 as zero.
// RULE2: an all-zero high address means 32-bit message writes, anything else means 64-bit.
// RULE3: the message data word is 16 bits, read/write, and resets to zero.
// RULE4: message data bits 15:4 always go out exactly as software wrote them.
// RULE5: only the low data bits set by the granted count may carry the vector number.
// RULE6: the bus release level reads as 30h and cannot be written.
// RULE7: a new frame timing value changes the frame period of every downstream bus at once.
// RULE8: the frame period is 59488 plus sixteen times the six-bit timing value.
// RULE9: the timing value sits in bits 5:0, resets to 20h, and bits 7:6 read zero.
// RULE10: the timing value survives every reset except the global and power-on reset.
// RULE11: the express capability identifier reads as 10h.
// RULE12: the express capability next pointer reads as c0h.
// RULE13: the express capabilities halfword reads as 0002h.
// RULE14: the granted count maps interrupters to one, two, four or own messages.
// RULE15: no message write is sent while the message enable bit is clear.
// RULE16: an enabled interrupter event sends one write of folded data to the programmed address.
`default_nettype none
module msi_and_frame_adjust_config
    import msi_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic function_reset,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic irq_valid,
    input wire logic [2:0] irq_interrupter,
    output logic irq_ready,
    input wire logic msg_ready,
    output logic msg_valid,
    output logic msg_wide,
    output logic [63:0] msg_addr,
    output logic [15:0] msg_data,
    output logic [5:0] frame_trim,
    output logic [15:0] sof_period,
    output logic irq_message_enable,
    output logic [2:0] granted_vector_count
);
    logic [29:0] addr_lo_q;
    logic [31:0] addr_hi_q;
    logic [15:0] data_q;
    logic enable_q;
    logic [2:0] count_q;
    logic [5:0] trim_q;
    logic [15:0] sof_q;
    logic [31:0] rd_d;
    logic [31:0] merged;
    logic [15:0] ctrl_view;
    logic [15:0] folded;
    logic launch;
    logic wr;
    logic rd;

    msi_msg_if msg_ch();

    assign wr = cfg_req && cfg_write;
    assign rd = cfg_req && !cfg_write;

    // write data merged against the addressed dword, shared by all writable words
    assign merged = merge_bytes(rd_d, cfg_wdata, cfg_byte_en);

    // message control halfword as software sees it
    always_comb begin
        ctrl_view = 16'h0;
        ctrl_view[CTRL_EN_BIT] = enable_q;
        ctrl_view[CTRL_CAP_LSB +: 3] = MSG_CAP_CODE;
        ctrl_view[CTRL_COUNT_LSB +: 3] = count_q;
        ctrl_view[CTRL_WIDE_BIT] = 1'b1;
    end

    // read mux; unmapped dwords read zero
    always_comb begin
        if (dword_hit(cfg_addr, OFF_MSI_ID)) begin
            rd_d = {ctrl_view, RST_MSI_NEXT, RST_MSI_ID};
        end else if (dword_hit(cfg_addr, OFF_ADDR_LO)) begin
            rd_d = {addr_lo_q, 2'b00}; // RULE1
        end else if (dword_hit(cfg_addr, OFF_ADDR_HI)) begin
            rd_d = addr_hi_q;
        end else if (dword_hit(cfg_addr, OFF_DATA)) begin
            rd_d = {16'h0, data_q}; // RULE3
        end else if (dword_hit(cfg_addr, OFF_RELEASE)) begin
            rd_d = {16'h0, 2'b00, trim_q, RST_RELEASE}; // RULE6 RULE9
        end else if (dword_hit(cfg_addr, OFF_PCIE_ID)) begin
            rd_d = {RST_PCIE_CAPS, RST_PCIE_NEXT, RST_PCIE_ID}; // RULE11 RULE12 RULE13
        end else begin
            rd_d = 32'h0;
        end
    end

    // answer one cycle after the request, read data from a flip-flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h0;
        end else begin
            cfg_ack <= cfg_req;
            cfg_rdata <= rd ? rd_d : 32'h0;
        end
    end

    // message control: enable and granted count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0;
            count_q <= RST_COUNT;
        end else if (function_reset) begin
            enable_q <= 1'b0;
            count_q <= RST_COUNT;
        end else if (wr && dword_hit(cfg_addr, OFF_MSI_CTRL) && cfg_byte_en[2]) begin
            enable_q <= merged[16 + CTRL_EN_BIT]; // RULE15
            count_q <= merged[16 + CTRL_COUNT_LSB +: 3]; // RULE14
        end
    end

    // message address words; low two bits are not stored at all
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_lo_q <= RST_ADDR[31:2];
            addr_hi_q <= RST_ADDR;
        end else if (function_reset) begin
            addr_lo_q <= RST_ADDR[31:2];
            addr_hi_q <= RST_ADDR;
        end else if (wr && dword_hit(cfg_addr, OFF_ADDR_LO)) begin
            addr_lo_q <= merged[31:2]; // RULE1
        end else if (wr && dword_hit(cfg_addr, OFF_ADDR_HI)) begin
            addr_hi_q <= merged; // RULE2
        end
    end

    // message data word; upper halfword of its dword is reserved
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_q <= RST_DATA;
        end else if (function_reset) begin
            data_q <= RST_DATA;
        end else if (wr && dword_hit(cfg_addr, OFF_DATA)) begin
            data_q <= merged[15:0]; // RULE3
        end
    end

    // sticky frame trim: rst stands for global and power-on reset only,
    // so a function reset deliberately leaves it alone
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trim_q <= RST_TRIM; // RULE10
            sof_q <= RST_SOF;
        end else if (wr && dword_hit(cfg_addr, OFF_TRIM) && cfg_byte_en[OFF_TRIM[1:0]]) begin
            trim_q <= merged[13:8]; // RULE9
            sof_q <= SOF_BASE + {6'h00, merged[13:8], 4'h0}; // RULE8
        end
    end

    // one trim and one period feed every downstream bus together
    assign frame_trim = trim_q; // RULE7
    assign sof_period = sof_q;
    assign irq_message_enable = enable_q;
    assign granted_vector_count = count_q;

    msi_vector_fold u_fold (
        .data_word(data_q),
        .vector_count(count_q),
        .interrupter(irq_interrupter),
        .folded(folded)
    );

    // source stalls while disabled or while a write is outstanding
    assign irq_ready = enable_q && !msg_ch.busy; // RULE15
    assign launch = irq_valid && irq_ready; // RULE16
    assign msg_ch.launch = launch;
    assign msg_ch.addr = {addr_hi_q, addr_lo_q, 2'b00};
    assign msg_ch.data = folded;

    msi_write_sender u_sender (
        .clock(clock),
        .rst(rst),
        .req(msg_ch.sender),
        .msg_ready(msg_ready),
        .msg_valid(msg_valid),
        .msg_wide(msg_wide),
        .msg_addr(msg_addr),
        .msg_data(msg_data)
    );

    // checks on the register view
    property p_addr_lo_read;
        @(posedge clock) disable iff (rst)
        rd && dword_hit(cfg_addr, OFF_ADDR_LO) |=> cfg_ack && cfg_rdata[1:0] == 2'b00
            && cfg_rdata[31:2] == $past(addr_lo_q);
    endproperty
    a_addr_lo_read: assert property (p_addr_lo_read) else $error("low address read wrong"); // RULE1

    property p_data_write;
        @(posedge clock) disable iff (rst || function_reset)
        wr && dword_hit(cfg_addr, OFF_DATA) && cfg_byte_en[1:0] == 2'b11
            |=> data_q == $past(cfg_wdata[15:0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("message data not stored"); // RULE3

    property p_release_read;
        @(posedge clock) disable iff (rst)
        rd && dword_hit(cfg_addr, OFF_RELEASE) |=> cfg_rdata[7:0] == 8'h30
            && cfg_rdata[15:14] == 2'b00;
    endproperty
    a_release_read: assert property (p_release_read) else $error("release level wrong"); // RULE6

    property p_trim_period;
        @(posedge clock) disable iff (rst)
        wr && dword_hit(cfg_addr, OFF_TRIM) && cfg_byte_en[1]
            |=> sof_period == 16'he860 + {6'h00, $past(cfg_wdata[13:8]), 4'h0}
            && frame_trim == $past(cfg_wdata[13:8]);
    endproperty
    a_trim_period: assert property (p_trim_period) else $error("frame period not updated"); // RULE8

    property p_trim_sticky;
        @(posedge clock) disable iff (rst)
        function_reset && !wr |=> $stable(frame_trim) && $stable(sof_period);
    endproperty
    a_trim_sticky: assert property (p_trim_sticky) else $error("trim lost on function reset"); // RULE10

    property p_pcie_read;
        @(posedge clock) disable iff (rst)
        rd && dword_hit(cfg_addr, OFF_PCIE_ID) |=> cfg_rdata == 32'h0002_c010;
    endproperty
    a_pcie_read: assert property (p_pcie_read) else $error("express capability wrong"); // RULE11

    // checks on message generation
    property p_no_send_disabled;
        @(posedge clock) disable iff (rst)
        !enable_q |-> !launch ##1 (!msg_valid || $past(msg_valid));
    endproperty
    a_no_send_disabled: assert property (p_no_send_disabled) else $error("send while disabled"); // RULE15

    property p_launch_write;
        @(posedge clock) disable iff (rst)
        launch |=> msg_valid && msg_addr == {$past(addr_hi_q), $past(addr_lo_q), 2'b00};
    endproperty
    a_launch_write: assert property (p_launch_write) else $error("write not issued"); // RULE16

    property p_fixed_bits;
        @(posedge clock) disable iff (rst)
        launch |=> msg_data[15:4] == $past(data_q[15:4]);
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed payload altered"); // RULE4

    property p_fold_two;
        @(posedge clock) disable iff (rst)
        launch && count_q == 3'h1 |=> msg_data[0] == $past(irq_interrupter[0])
            && msg_data[3:1] == $past(data_q[3:1]);
    endproperty
    a_fold_two: assert property (p_fold_two) else $error("two-vector fold wrong"); // RULE5

    property p_fold_four;
        @(posedge clock) disable iff (rst)
        launch && count_q == 3'h2 |=> msg_data[1:0] == $past(irq_interrupter[1:0])
            && msg_data[3:2] == $past(data_q[3:2]);
    endproperty
    a_fold_four: assert property (p_fold_four) else $error("four-vector fold wrong"); // RULE14

    property p_fold_one;
        @(posedge clock) disable iff (rst)
        launch && (count_q == 3'h0 || count_q > 3'h5) |=> msg_data == $past(data_q);
    endproperty
    a_fold_one: assert property (p_fold_one) else $error("single message altered"); // RULE14

    c_wide_send: cover property (@(posedge clock) disable iff (rst) msg_valid && msg_wide);
    c_stalled: cover property (@(posedge clock) disable iff (rst)
        msg_valid && !msg_ready ##1 msg_valid && msg_ready);
    c_eight: cover property (@(posedge clock) disable iff (rst) launch && count_q == 3'h3);
    c_trim_wr: cover property (@(posedge clock) disable iff (rst)
        wr && dword_hit(cfg_addr, OFF_TRIM));
endmodule : msi_and_frame_adjust_config
`default_nettype wire

// ==== shared/msi_cfg_pkg.sv ====
`default_nettype none
package msi_cfg_pkg;
    // configuration byte offsets; decoding uses the dword part, the lane uses the low bits
    localparam logic [7:0] OFF_MSI_ID = 8'h48;
    localparam logic [7:0] OFF_MSI_NEXT = 8'h49;
    localparam logic [7:0] OFF_MSI_CTRL = 8'h4a;
    localparam logic [7:0] OFF_ADDR_LO = 8'h4c;
    localparam logic [7:0] OFF_ADDR_HI = 8'h50;
    localparam logic [7:0] OFF_DATA = 8'h54;
    localparam logic [7:0] OFF_RELEASE = 8'h60;
    localparam logic [7:0] OFF_TRIM = 8'h61;
    localparam logic [7:0] OFF_PCIE_ID = 8'h70;
    localparam logic [7:0] OFF_PCIE_NEXT = 8'h71;
    localparam logic [7:0] OFF_PCIE_CAPS = 8'h72;
    // field positions inside the message control halfword
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CAP_LSB = 1;
    localparam int CTRL_COUNT_LSB = 4;
    localparam int CTRL_WIDE_BIT = 7;
    // reset and fixed values
    localparam logic [7:0] RST_MSI_ID = 8'h05;
    localparam logic [7:0] RST_MSI_NEXT = 8'h70;
    localparam logic [2:0] RST_COUNT = 3'h0;
    localparam logic [2:0] MSG_CAP_CODE = 3'h3;
    localparam logic [31:0] RST_ADDR = 32'h0000_0000;
    localparam logic [15:0] RST_DATA = 16'h0000;
    localparam logic [7:0] RST_RELEASE = 8'h30;
    localparam logic [5:0] RST_TRIM = 6'h20;
    localparam logic [7:0] RST_PCIE_ID = 8'h10;
    localparam logic [7:0] RST_PCIE_NEXT = 8'hc0;
    localparam logic [15:0] RST_PCIE_CAPS = 16'h0002;
    // frame period in high-speed bit times; each trim step is worth sixteen of them
    localparam logic [15:0] SOF_BASE = 16'he860;
    localparam logic [15:0] RST_SOF = SOF_BASE + {6'h00, RST_TRIM, 4'h0};

    // byte-enable merge of a write into a dword
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] wr_v,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wr_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // dword hit test of a byte address against a register offset
    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction : dword_hit
endpackage : msi_cfg_pkg
`default_nettype wire

// ==== shared/msi_msg_if.sv ====
`default_nettype none
// request from the register bank to the message write sender
interface msi_msg_if;
    logic launch;
    logic [63:0] addr;
    logic [15:0] data;
    logic busy;
    modport issuer(output launch, output addr, output data, input busy);
    modport sender(input launch, input addr, input data, output busy);
endinterface : msi_msg_if
`default_nettype wire

// ==== hdl/msi_vector_fold.sv ====
`default_nettype none
module msi_vector_fold
    import msi_cfg_pkg::*;
(
    input wire logic [15:0] data_word,
    input wire logic [2:0] vector_count,
    input wire logic [2:0] interrupter,
    output logic [15:0] folded
);
    logic [3:0] vector_number_bits;
    logic [3:0] mask;

    // message number and modifiable low bits per granted count
    always_comb begin
        case (vector_count)
            3'h1: mask = 4'h1; // RULE5
            3'h2: mask = 4'h3;
            3'h3: mask = 4'h7;
            3'h4, 3'h5: mask = 4'hf; // only eight interrupters, bit 4 kept
            default: mask = 4'h0; // one message, reserved codes alike
        endcase
        vector_number_bits = {1'b0, interrupter} & mask; // RULE14
    end

    // upper part passes untouched
    assign folded = {data_word[15:4], (data_word[3:0] & ~mask) | vector_number_bits}; // RULE4
endmodule : msi_vector_fold
`default_nettype wire

// ==== hdl/msi_write_sender.sv ====
`default_nettype none
module msi_write_sender
    import msi_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    msi_msg_if.sender req,
    input wire logic msg_ready,
    output logic msg_valid,
    output logic msg_wide,
    output logic [63:0] msg_addr,
    output logic [15:0] msg_data
);
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_t;
    tx_state_t state_q;

    // one write in flight; the bank stalls its source while busy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= TX_IDLE;
        end else begin
            case (state_q)
                TX_IDLE: if (req.launch) state_q <= TX_SEND;
                TX_SEND: if (msg_ready) state_q <= TX_IDLE;
                default: state_q <= TX_IDLE;
            endcase
        end
    end

    // payload captured at launch so later register writes cannot tear it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            msg_addr <= 64'h0;
            msg_data <= 16'h0;
            msg_wide <= 1'b0;
        end else if (req.launch && state_q == TX_IDLE) begin
            msg_addr <= req.addr; // RULE16
            msg_data <= req.data;
            msg_wide <= req.addr[63:32] != 32'h0; // RULE2
        end
    end

    assign msg_valid = state_q == TX_SEND;
    assign req.busy = state_q != TX_IDLE;

    property p_wide_mode;
        @(posedge clock) disable iff (rst)
        msg_valid |-> msg_wide == (msg_addr[63:32] != 32'h0);
    endproperty
    a_wide_mode: assert property (p_wide_mode) else $error("address width mode wrong"); // RULE2

    property p_hold;
        @(posedge clock) disable iff (rst)
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr) && $stable(msg_data);
    endproperty
    a_hold: assert property (p_hold) else $error("message changed while stalled"); // RULE16
endmodule : msi_write_sender
`default_nettype wire

// ==== testbench/msg_sink.sv ====
`default_nettype none
// far-side model: accepts message writes after a programmable stall
module msg_sink
    import msi_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic msg_valid,
    input wire logic msg_wide,
    input wire logic [63:0] msg_addr,
    input wire logic [15:0] msg_data,
    input wire logic [3:0] stall,
    output logic msg_ready,
    output int got_n,
    output int bad_n,
    output logic got_wide,
    output logic [63:0] got_addr,
    output logic [15:0] got_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [80:0] held_q;
    int wait_q;

    // ready only after the stall, so the issuer must hold its request meanwhile
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            msg_ready <= 1'b0;
            got_n <= 0;
            bad_n <= 0;
            wait_q <= 0;
            held_q <= '0;
            got_wide <= 1'b0;
            got_addr <= '0;
            got_data <= '0;
        end else if (msg_valid && msg_ready) begin
            got_n <= got_n + 1;
            got_wide <= msg_wide;
            got_addr <= msg_addr;
            got_data <= msg_data;
            msg_ready <= 1'b0;
            wait_q <= 0;
        end else if (msg_valid) begin
            // a pending write must not change while stalled
            if (wait_q > 0 && held_q !== {msg_wide, msg_addr, msg_data}) begin
                bad_n <= bad_n + 1;
            end
            held_q <= {msg_wide, msg_addr, msg_data};
            if (wait_q >= int'(stall)) begin
                msg_ready <= 1'b1;
            end
            wait_q <= wait_q + 1;
        end
    end
endmodule : msg_sink
`default_nettype wire

// ==== testbench/msi_and_frame_adjust_config_tb.sv ====
`default_nettype none
module msi_and_frame_adjust_config_tb
    import msi_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst, function_reset, cfg_req, cfg_write, cfg_ack, irq_valid, irq_ready;
    logic msg_ready, msg_valid, msg_wide, irq_message_enable, got_wide;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_byte_en, stall;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [2:0] irq_interrupter, granted_vector_count, intr;
    logic [63:0] msg_addr, got_addr;
    logic [15:0] msg_data, got_data, sof_period, mask, exp_data;
    logic [5:0] frame_trim;
    logic [15:0] masks [8] = '{16'h0000, 16'h0001, 16'h0003, 16'h0007,
                               16'h000f, 16'h000f, 16'h0000, 16'h0000};
    logic [5:0] trims [3] = '{6'h3f, 6'h00, 6'h15};
    int got_n, bad_n, n0;
    int fail_count = 0;
    int n_checks = 0;

    always #50 clock = ~clock;

    msi_and_frame_adjust_config i_dut (.clock(clock), .rst(rst),
        .function_reset(function_reset), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .irq_valid(irq_valid),
        .irq_interrupter(irq_interrupter), .irq_ready(irq_ready), .msg_ready(msg_ready),
        .msg_valid(msg_valid), .msg_wide(msg_wide), .msg_addr(msg_addr),
        .msg_data(msg_data), .frame_trim(frame_trim), .sof_period(sof_period),
        .irq_message_enable(irq_message_enable),
        .granted_vector_count(granted_vector_count));

    msg_sink i_sink (.clock(clock), .rst(rst), .msg_valid(msg_valid), .msg_wide(msg_wide),
        .msg_addr(msg_addr), .msg_data(msg_data), .stall(stall), .msg_ready(msg_ready),
        .got_n(got_n), .bad_n(bad_n), .got_wide(got_wide), .got_addr(got_addr),
        .got_data(got_data));

    task automatic close_out();
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one config access; answer is looked at in its single ack cycle
    task automatic cfg_access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                              input logic [31:0] d);
        @(posedge clock);
        cfg_req <= 1'b1;
        cfg_write <= wr;
        cfg_addr <= a;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_req <= 1'b0;
        #1;
        check(64'(cfg_ack), 64'h1);
    endtask : cfg_access

    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_access(1'b1, a, be, d);
    endtask : cfg_wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        cfg_access(1'b0, a, 4'hf, 32'h0000_0000);
        check(64'(cfg_rdata), 64'(exp));
    endtask : rd_chk

    // trim write with bits 7:6 set; they must read back as zero
    task automatic trim_chk(input logic [5:0] v);
        cfg_wr(OFF_TRIM, 4'h2, {16'h0000, 2'b11, v, 8'h00});
        check(64'(frame_trim), 64'(v));
        check(64'(sof_period), 64'(16'he860 + {6'h00, v, 4'h0}));
        rd_chk(OFF_RELEASE, {16'h0000, 2'b00, v, 8'h30});
    endtask : trim_chk

    // raise an event and hold it until the device is ready to take it
    task automatic fire(input logic [2:0] n);
        int i;
        logic rdy;
        n0 = got_n;
        @(posedge clock);
        irq_valid <= 1'b1;
        irq_interrupter <= n;
        i = 0;
        do begin
            #1;
            rdy = irq_ready;
            @(posedge clock);
            i++;
        end while (rdy !== 1'b1 && i < 50);
        irq_valid <= 1'b0;
        check(64'(rdy), 64'h1);
        #1;
        check(64'(irq_ready), 64'h0);
        i = 0;
        while (got_n == n0 && i < 50) begin
            @(posedge clock);
            #1;
            i++;
        end
        check(64'(got_n), 64'(n0 + 1));
    endtask : fire

    // watchdog, far beyond the few hundred cycles of the sequence
    initial begin
        #2000000;
        fail_count++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        function_reset = 1'b0;
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_addr = 8'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h0000_0000;
        irq_valid = 1'b0;
        irq_interrupter = 3'h0;
        stall = 4'h0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rd_chk(OFF_ADDR_LO, 32'h0000_0000);
        rd_chk(OFF_ADDR_HI, 32'h0000_0000);
        rd_chk(OFF_DATA, 32'h0000_0000);
        rd_chk(OFF_RELEASE, 32'h0000_2030);
        rd_chk(OFF_PCIE_ID, 32'h0002_c010);
        rd_chk(8'hfc, 32'h0000_0000);
        check(64'(sof_period), 64'(16'hea60));
        // read-only places ignore writes
        cfg_wr(OFF_RELEASE, 4'h1, 32'h0000_00ff);
        cfg_wr(OFF_PCIE_ID, 4'hf, 32'hffff_ffff);
        rd_chk(OFF_RELEASE, 32'h0000_2030);
        rd_chk(OFF_PCIE_ID, 32'h0002_c010);
        cfg_wr(OFF_ADDR_LO, 4'hf, 32'hffff_ffff);
        rd_chk(OFF_ADDR_LO, 32'hffff_fffc);
        cfg_wr(OFF_DATA, 4'hf, 32'hffff_ffff);
        rd_chk(OFF_DATA, 32'h0000_ffff);
        for (int t = 0; t < 3; t++) begin
            trim_chk(trims[t]);
        end
        // function reset clears the bank but not the trim
        @(posedge clock);
        function_reset <= 1'b1;
        @(posedge clock);
        function_reset <= 1'b0;
        #1;
        check(64'(frame_trim), 64'(6'h15));
        rd_chk(OFF_ADDR_LO, 32'h0000_0000);
        rd_chk(OFF_DATA, 32'h0000_0000);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
        check(64'(frame_trim), 64'(6'h20));
        check(64'(sof_period), 64'(16'hea60));
        // message writes for every granted count, odd passes with a high address
        cfg_wr(OFF_ADDR_LO, 4'hf, 32'h1000_0007);
        cfg_wr(OFF_DATA, 4'h3, 32'h0000_123a);
        for (int k = 0; k < 8; k++) begin
            cfg_wr(OFF_ADDR_HI, 4'hf, {31'h0, 1'(k)});
            cfg_wr(OFF_MSI_CTRL, 4'h4, {9'h000, 3'(k), 4'h1, 16'h0000});
            check(64'(granted_vector_count), 64'(k));
            check(64'(irq_message_enable), 64'h1);
            rd_chk(OFF_MSI_ID, {8'h00, 1'b1, 3'(k), 4'h7, 16'h7005});
            stall = 4'(k);
            intr = 3'(7 - k);
            mask = masks[k];
            exp_data = (16'h123a & ~mask) | ({13'h0000, intr} & mask);
            fire(intr);
            check(64'(got_data), 64'(exp_data));
            check(got_addr, {31'h0, 1'(k), 32'h1000_0004});
            check(64'(got_wide), 64'(k % 2));
        end
        fire(3'h2);
        check(64'(bad_n), 64'h0);
        // with the enable clear an event is stalled and nothing is sent
        cfg_wr(OFF_MSI_CTRL, 4'h4, 32'h0000_0000);
        check(64'(irq_message_enable), 64'h0);
        n0 = got_n;
        @(posedge clock);
        irq_valid <= 1'b1;
        repeat (20) begin
            @(posedge clock);
            #1;
            check(64'(irq_ready), 64'h0);
        end
        @(posedge clock);
        irq_valid <= 1'b0;
        check(64'(got_n), 64'(n0));
        close_out();
    end
endmodule : msi_and_frame_adjust_config_tb
`default_nettype wire
